// [rtl/sld_pkg.sv]
// constants for the serial latched output driver
// assumes a single core clock domain at 200 MHz
package sld_pkg;
  localparam int unsigned chan_count = 10;
  localparam logic [9:0] latch_reset = 10'h000;
  localparam logic [9:0] shift_reset = 10'h000;
  localparam logic [9:0] oe_all_off = 10'h3ff;
  localparam logic [9:0] drive_zero = 10'h000;
  typedef enum logic [1:0] {sld_idle, sld_shift, sld_pass} sld_mode_t;
endpackage

// [rtl/sld_shifter.sv]
// ten bit msb-first serial shift register
// assumes serial clock and data are synchronous to core_clk
`timescale 1ns/1ps
module sld_shifter (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic shift_en,
  input wire logic serial_data_in,
  output logic [9:0] shift_q
);
  logic [9:0] shift_reg;
  logic [9:0] shift_next;

  // older bits move toward the msb so the first bit sent lands at bit 9
  assign shift_next = shift_en ? {shift_reg[8:0], serial_data_in} : shift_reg;
  assign shift_q = shift_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      shift_reg <= sld_pkg::shift_reset;
    else
      shift_reg <= shift_next;
  end
endmodule

// [rtl/sld_driver.sv]
// ten channel serial latched output driver top
// assumes all inputs synchronous to core_clk; outputs drive tri-state pads
// How it works
// - serial data enters a ten bit shift register, msb first
// - latch follows the shift register while latch strobe is high
// - a channel drives on only with latch bit one and blanking low
// - blanking high puts every channel output in high impedance
// - ten channel outputs, first to last, one latch bit each
// - overvoltage from supply sense forces all outputs to high impedance
`timescale 1ns/1ps
module sld_driver (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic serial_clk,
  input wire logic serial_data_in,
  input wire logic latch_strobe,
  input wire logic blank,
  input wire logic supply_sense,
  output logic [9:0] channel_out,
  output logic [9:0] channel_oe_n,
  output logic [9:0] latch_q
);
  logic serial_clk_reg;
  logic [9:0] shift_q;
  logic [9:0] latch_reg;
  logic [9:0] latch_next;
  logic [9:0] out_reg;
  logic [9:0] oe_n_reg;
  logic [9:0] oe_n_next;
  logic shift_edge;
  logic outputs_off;
  logic [9:0] out_next;

  // pin data for one set of latch bits; all zero when the channels are cut off
  function automatic logic [9:0] drive_mask(input logic off, input logic [9:0] bits);
    logic [9:0] mask;
    mask = off ? sld_pkg::drive_zero : bits;
    return mask;
  endfunction

  // serial_clk is sampled directly, being synchronous; the data bit is taken
  // in the same cycle as the first high sample, so no data delay is needed
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      serial_clk_reg <= 1'b0;
    else
      serial_clk_reg <= serial_clk;
  end

  assign shift_edge = serial_clk & ~serial_clk_reg;

  sld_shifter u_shift (
    .core_clk(core_clk),
    .rstn(rstn),
    .shift_en(shift_edge),
    .serial_data_in(serial_data_in),
    .shift_q(shift_q)
  );

  // transparent while strobe high, one cycle behind the shift register
  assign latch_next = latch_strobe ? shift_q : latch_reg;
  assign outputs_off = blank | supply_sense;
  // data lines carry the latch value, zeroed while outputs are off; enables decide whether a pin is driven
  // an enable is the inverse of the gated data, so a zero bit leaves its pin floating
  assign out_next = drive_mask(outputs_off, latch_reg);
  assign oe_n_next = ~drive_mask(outputs_off, latch_reg);

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      latch_reg <= sld_pkg::latch_reset;
      out_reg <= sld_pkg::drive_zero;
      oe_n_reg <= sld_pkg::oe_all_off;
    end
    else
    begin
      latch_reg <= latch_next;
      out_reg <= out_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign channel_out = out_reg;
  assign channel_oe_n = oe_n_reg;
  assign latch_q = latch_reg;

  property p_hold;
    @(posedge core_clk) disable iff (!rstn)
      !latch_strobe |=> latch_reg == $past(latch_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed with strobe low");

  property p_pass;
    @(posedge core_clk) disable iff (!rstn)
      latch_strobe |=> latch_reg == $past(shift_q);
  endproperty
  a_pass: assert property (p_pass) else $error("latch not passing data");

  property p_blank;
    @(posedge core_clk) disable iff (!rstn)
      blank |=> channel_oe_n == sld_pkg::oe_all_off;
  endproperty
  a_blank: assert property (p_blank) else $error("output driven while blanked");

  property p_ov;
    @(posedge core_clk) disable iff (!rstn)
      supply_sense |=> channel_oe_n == sld_pkg::oe_all_off && channel_out == sld_pkg::drive_zero;
  endproperty
  a_ov: assert property (p_ov) else $error("output driven during overvoltage");

  property p_on;
    @(posedge core_clk) disable iff (!rstn)
      !outputs_off |=> channel_oe_n == ~$past(latch_reg);
  endproperty
  a_on: assert property (p_on) else $error("enable does not follow latch");

  property p_data;
    @(posedge core_clk) disable iff (!rstn)
      !outputs_off |=> channel_out == $past(latch_reg);
  endproperty
  a_data: assert property (p_data) else $error("channel data wrong");

  property p_shift;
    @(posedge core_clk) disable iff (!rstn)
      shift_edge |=> shift_q == {$past(shift_q[8:0]), $past(serial_data_in)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift register did not advance");

  property p_noshift;
    @(posedge core_clk) disable iff (!rstn)
      !shift_edge |=> shift_q == $past(shift_q);
  endproperty
  a_noshift: assert property (p_noshift) else $error("shift without clock edge");

  // reset leaves every pin floating and the latch cleared
  property p_reset;
    @(posedge core_clk)
      !rstn |=> channel_oe_n == sld_pkg::oe_all_off && channel_out == sld_pkg::drive_zero
        && latch_q == sld_pkg::latch_reset;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not off after reset");

  // a serial clock held high over several samples must shift only once
  sequence s_clk_held;
    serial_clk ##1 serial_clk;
  endsequence

  property p_shift_once;
    @(posedge core_clk) disable iff (!rstn)
      s_clk_held |=> shift_q == $past(shift_q);
  endproperty
  a_shift_once: assert property (p_shift_once) else $error("held serial clock shifted twice");

  property p_low_clk;
    @(posedge core_clk) disable iff (!rstn)
      !serial_clk |=> shift_q == $past(shift_q);
  endproperty
  a_low_clk: assert property (p_low_clk) else $error("shift while serial clock low");

  // strobe then two enabled cycles: pins show the word that was in the shifter
  sequence s_strobe_on;
    latch_strobe && !outputs_off ##1 !outputs_off;
  endsequence

  property p_walk;
    @(posedge core_clk) disable iff (!rstn)
      s_strobe_on |=> channel_oe_n == ~$past(shift_q, 2);
  endproperty
  a_walk: assert property (p_walk) else $error("strobed word not on the pins");

  // two strobe-low cycles in a row keep the latch frozen throughout
  sequence s_strobe_low;
    !latch_strobe ##1 !latch_strobe;
  endsequence

  property p_hold_run;
    @(posedge core_clk) disable iff (!rstn)
      s_strobe_low |=> latch_reg == $past(latch_reg, 2);
  endproperty
  a_hold_run: assert property (p_hold_run) else $error("latch moved during strobe low");

  property p_blank_data;
    @(posedge core_clk) disable iff (!rstn)
      blank |=> channel_out == sld_pkg::drive_zero;
  endproperty
  a_blank_data: assert property (p_blank_data) else $error("pin data left while blanked");

  property p_blank_steady;
    @(posedge core_clk) disable iff (!rstn)
      blank ##1 blank |=> $stable(channel_oe_n);
  endproperty
  a_blank_steady: assert property (p_blank_steady) else $error("enables moved while blanked");

  // data may only be high on a pin whose driver is on
  property p_data_gated;
    @(posedge core_clk) disable iff (!rstn)
      (channel_out & channel_oe_n) == sld_pkg::drive_zero;
  endproperty
  a_data_gated: assert property (p_data_gated) else $error("data on an undriven pin");

  property p_from_latch;
    @(posedge core_clk) disable iff (!rstn)
      ##1 (channel_out & ~$past(latch_reg)) == sld_pkg::drive_zero;
  endproperty
  a_from_latch: assert property (p_from_latch) else $error("pin on without its latch bit");
endmodule

// [verification/sld_ctrl_model.sv]
// controller stand-in: shifts one word msb first, then may strobe the latch
// assumes go is a one-cycle request on core_clk; done stays high until next go
`timescale 1ns/1ps
module sld_ctrl_model (
  input wire logic core_clk,
  input wire logic go,
  input wire logic do_latch,
  input wire logic [9:0] word,
  output logic serial_clk = 1'b0,
  output logic serial_data_in = 1'b0,
  output logic latch_strobe = 1'b0,
  output logic done = 1'b0
);
  always @(posedge core_clk)
    if (go)
    begin
      done <= 1'b0;
      for (int i = 9; i >= 0; i--)
      begin
        @(posedge core_clk);
        serial_data_in <= word[i];
        serial_clk <= 1'b1;
        // held high two samples so the design must not shift twice
        repeat (2) @(posedge core_clk);
        serial_clk <= 1'b0;
        // stale data is not held once the bit is taken
        serial_data_in <= ~word[i];
      end
      if (do_latch)
      begin
        @(posedge core_clk) latch_strobe <= 1'b1;
        @(posedge core_clk) latch_strobe <= 1'b0;
      end
      @(posedge core_clk) done <= 1'b1;
    end
endmodule

// [verification/sld_driver_tb.sv]
// self-checking bench for the serial latched output driver
// assumes the controller model drives the serial side
`timescale 1ns/1ps
module sld_driver_tb;
  logic core_clk = 1'b0, rstn = 1'b0, go = 1'b0, do_latch = 1'b1;
  logic blank = 1'b1, supply_sense = 1'b0;
  logic [9:0] sel_word = 10'h000, blink_word = 10'h000;
  logic [9:0] word = 10'h000;
  logic serial_clk, serial_data_in, latch_strobe, done;
  logic [9:0] channel_out, channel_oe_n, latch_q;
  int errors = 0, checks = 0, cycles = 0;
  always #2.5 core_clk = ~core_clk;
  sld_driver dut (.core_clk(core_clk), .rstn(rstn), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .latch_strobe(latch_strobe), .blank(blank),
    .supply_sense(supply_sense), .channel_out(channel_out),
    .channel_oe_n(channel_oe_n), .latch_q(latch_q));
  sld_ctrl_model ctrl (.core_clk(core_clk), .go(go), .do_latch(do_latch), .word(word),
    .serial_clk(serial_clk), .serial_data_in(serial_data_in),
    .latch_strobe(latch_strobe), .done(done));
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      wrap_up();
    end
  end
  task automatic send(input logic [9:0] w, input logic l);
    word <= w;
    do_latch <= l;
    go <= 1'b1;
    @(posedge core_clk) go <= 1'b0;
    // done from the last word is cleared at the edge above that takes go, one edge before this
    @(posedge core_clk);
    for (int n = 0; n < 60 && done !== 1'b1; n++)
      @(posedge core_clk);
    repeat (3) @(posedge core_clk);
  endtask
  task automatic t_latch_drive;
    blank <= 1'b0;
    send(10'h2a5, 1'b1);
    check(latch_q, 10'h2a5);
    check(channel_out, 10'h2a5);
    check(channel_oe_n, 10'h15a);
    // shifting without a strobe must leave the latch alone
    send(10'h0f0, 1'b0);
    check(latch_q, 10'h2a5);
    blank <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(channel_oe_n, 10'h3ff);
  endtask
  // blink phases shortened: 300 ms would far outlast the run
  task automatic t_controller;
    supply_sense <= 1'b0;
    blank <= 1'b0;
    sel_word = sel_word ^ 10'h008;
    sel_word = sel_word ^ 10'h200;
    sel_word = sel_word ^ 10'h008;
    blink_word = blink_word ^ 10'h001;
    send(sel_word | blink_word, 1'b1);
    check(latch_q, 10'h201);
    send(sel_word & ~blink_word, 1'b1);
    check(latch_q, 10'h200);
    check(channel_oe_n, 10'h1ff);
    check(channel_out, 10'h200);
  endtask
  task automatic t_tristate;
    blank <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(channel_oe_n, 10'h3ff);
    check(channel_out, 10'h000);
    blank <= 1'b0;
    supply_sense <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(channel_oe_n, 10'h3ff);
    check(channel_out, 10'h000);
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    check(channel_oe_n, 10'h3ff);
    t_latch_drive();
    t_tristate();
    t_controller();
    wrap_up();
  end
endmodule
